// ---- src/tpi_pkg.sv ----
package tpi_pkg;
	// Slave address layout: fixed prefix, two strap bits, direction bit
	localparam logic [4:0] ADDR_PREFIX = 5'h0b;
	localparam logic [7:0] WIPER_MIDSCALE = 8'h80;
	// Instruction byte field positions
	localparam int INS_TRIM2 = 7;
	localparam int INS_SD = 6;
	localparam int INS_PROG = 5;
	localparam int INS_OW = 3;
	// Validation status codes, upper two bits of the validation byte
	localparam logic [1:0] VAL_READY = 2'h0;
	localparam logic [1:0] VAL_FAULT = 2'h2;
	localparam logic [1:0] VAL_DONE = 2'h3;
	// Clock and fuse programming time
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned FUSE_PROG_MS = 400;
	localparam int unsigned FUSE_PROG_CYC = FUSE_PROG_MS * (CLK_HZ / 1000);
	// Link framing
	localparam logic [3:0] BITS_DATA = 4'h8;
	localparam logic [3:0] BITS_FRAME = 4'h9;
	localparam int unsigned QTR_CYC = 5;
	// Controller register byte offsets
	localparam logic [4:0] REG_CMD = 5'h00;
	localparam logic [4:0] REG_INSTR = 5'h04;
	localparam logic [4:0] REG_DATA = 5'h08;
	localparam logic [4:0] REG_STAT = 5'h0c;
	// Controller register fields and reset values
	localparam int CMD_READ = 2;
	localparam logic [7:0] INSTR_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [1:0] BYTES_LAST = 2'h2;
endpackage : tpi_pkg

// ---- src/tpi_if.sv ----
`timescale 1ns/1ps
interface tpi_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// Open-drain wires with pull-up: any enabled low driver pulls the line low
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
	modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
		output host_sda_o, output host_sda_oe);
endinterface : tpi_if

// ---- src/tpi_dev.sv ----
`timescale 1ns/1ps
module tpi_dev #(
	parameter int unsigned FUSE_PROG_CYC = tpi_pkg::FUSE_PROG_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	tpi_if.dev bus,
	input wire logic [1:0] addr_strap,
	input wire logic power_cycle,
	input wire logic fuse_fault,
	output logic [7:0] wiper_code,
	output logic wiper_shutdown,
	output logic [1:0] fuse_status,
	output logic prog_busy
);
	typedef enum logic [2:0] {
		TPI_IDLE, TPI_ADDR, TPI_INSTR, TPI_WDATA, TPI_READ, TPI_IGNORE
	} tpi_state_e;

	tpi_state_e st_q;
	logic [2:0] scl_q;
	logic [2:0] sda_q;
	logic [1:0] strap_s1_q;
	logic [1:0] strap_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic [7:0] tx_q;
	logic [7:0] ins_q;
	logic oe_q;
	logic rd_sel_q;
	logic [7:0] wiper_q;
	logic sd_q;
	logic ow_q;
	logic blown1_q;
	logic blown2_q;
	logic [7:0] fuse_val_q;
	logic [1:0] status_q;
	logic busy_q;
	logic arr_q;
	logic [7:0] prog_val_q;
	logic [31:0] prog_cnt_q;

	// Edge and condition detection on the synchronised link lines
	wire scl_w = scl_q[1];
	wire sda_w = sda_q[1];
	wire rise_w = scl_w & ~scl_q[2];
	wire fall_w = ~scl_w & scl_q[2];
	wire start_w = scl_w & scl_q[2] & sda_q[2] & ~sda_w;
	wire stop_w = scl_w & scl_q[2] & ~sda_q[2] & sda_w;
	wire ack_slot_w = fall_w && bit_q == tpi_pkg::BITS_DATA;
	wire end_slot_w = fall_w && bit_q == tpi_pkg::BITS_FRAME;
	wire match_w = sh_q[7:3] == tpi_pkg::ADDR_PREFIX && sh_q[2:1] == strap_q;
	wire instr_take_w = ack_slot_w && st_q == TPI_INSTR;
	wire data_take_w = ack_slot_w && st_q == TPI_WDATA;
	wire fused_w = blown1_q | blown2_q;
	wire [7:0] tx_next_w = rd_sel_q ? {status_q, 6'h00} : wiper_q;
	wire prog_ok_w = ~busy_q && status_q == tpi_pkg::VAL_READY && ~blown2_q
		&& (ins_q[tpi_pkg::INS_TRIM2] | ~blown1_q);
	wire prog_go_w = data_take_w & ins_q[tpi_pkg::INS_PROG] & prog_ok_w;
	wire prog_end_w = busy_q && prog_cnt_q == FUSE_PROG_CYC - 1;

	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe = oe_q;
	assign wiper_code = wiper_q;
	assign wiper_shutdown = sd_q;
	assign fuse_status = status_q;
	assign prog_busy = busy_q;

	// Two-flop synchronisers; third stage only feeds edge detection
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
			strap_s1_q <= 2'h0;
			strap_q <= 2'h0;
		end else begin
			scl_q <= {scl_q[1:0], bus.scl};
			sda_q <= {sda_q[1:0], bus.sda};
			strap_s1_q <= addr_strap;
			strap_q <= strap_s1_q;
		end
	end

	// Bit counter and receive shift register, clocked by link clock rises
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			bit_q <= 4'h0;
			sh_q <= 8'h00;
		end else if (start_w || stop_w) begin
			bit_q <= 4'h0;
		end else if (rise_w) begin
			if (bit_q < tpi_pkg::BITS_DATA) begin
				sh_q <= {sh_q[6:0], sda_w};
			end
			bit_q <= bit_q + 4'h1;
		end else if (end_slot_w) begin
			bit_q <= 4'h0;
		end
	end

	// Transfer sequencing; data line moves only after a clock fall
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			st_q <= TPI_IDLE;
			oe_q <= 1'b0;
			tx_q <= 8'h00;
			ins_q <= 8'h00;
			rd_sel_q <= 1'b0;
		end else if (start_w) begin
			st_q <= TPI_ADDR;
			oe_q <= 1'b0;
		end else if (stop_w) begin
			st_q <= TPI_IDLE;
			oe_q <= 1'b0;
		end else if (rise_w && st_q == TPI_READ && bit_q == tpi_pkg::BITS_DATA) begin
			if (sda_w) begin
				st_q <= TPI_IGNORE;
			end
		end else if (ack_slot_w) begin
			case (st_q)
				TPI_ADDR: begin
					if (match_w) begin
						oe_q <= 1'b1;
					end else begin
						st_q <= TPI_IGNORE;
					end
				end
				TPI_INSTR: begin
					ins_q <= sh_q;
					oe_q <= 1'b1;
				end
				TPI_WDATA: oe_q <= 1'b1;
				default: oe_q <= 1'b0;
			endcase
		end else if (end_slot_w) begin
			oe_q <= 1'b0;
			case (st_q)
				TPI_ADDR: begin
					rd_sel_q <= 1'b0;
					if (sh_q[0]) begin
						st_q <= TPI_READ;
						tx_q <= wiper_q;
						oe_q <= ~wiper_q[7];
						rd_sel_q <= 1'b1;
					end else begin
						st_q <= TPI_INSTR;
					end
				end
				TPI_INSTR: st_q <= TPI_WDATA;
				TPI_READ: begin
					tx_q <= tx_next_w;
					oe_q <= ~tx_next_w[7];
					rd_sel_q <= ~rd_sel_q;
				end
				default: st_q <= st_q;
			endcase
		end else if (fall_w && st_q == TPI_READ && bit_q != 4'h0) begin
			tx_q <= {tx_q[6:0], 1'b0};
			oe_q <= ~tx_q[6];
		end
	end

	// Wiper, shutdown and overwrite state
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			wiper_q <= tpi_pkg::WIPER_MIDSCALE;
			sd_q <= 1'b0;
			ow_q <= 1'b0;
		end else if (power_cycle) begin
			wiper_q <= fused_w ? fuse_val_q : tpi_pkg::WIPER_MIDSCALE;
			sd_q <= 1'b0;
			ow_q <= 1'b0;
		end else if (instr_take_w) begin
			sd_q <= sh_q[tpi_pkg::INS_SD];
			ow_q <= sh_q[tpi_pkg::INS_OW];
			if (ow_q && !sh_q[tpi_pkg::INS_OW] && fused_w) begin
				wiper_q <= fuse_val_q;
			end
		end else if (data_take_w && (!fused_w || ow_q || prog_go_w)) begin
			// An accepted burn also fixes the wiper at the burnt value
			wiper_q <= sh_q;
		end
	end

	// Fuse programming; status changes only when the burn completes
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			busy_q <= 1'b0;
			arr_q <= 1'b0;
			prog_val_q <= 8'h00;
			prog_cnt_q <= 32'h0;
			blown1_q <= 1'b0;
			blown2_q <= 1'b0;
			fuse_val_q <= tpi_pkg::WIPER_MIDSCALE;
			status_q <= tpi_pkg::VAL_READY;
		end else if (prog_go_w) begin
			busy_q <= 1'b1;
			arr_q <= ins_q[tpi_pkg::INS_TRIM2];
			prog_val_q <= sh_q;
			prog_cnt_q <= 32'h0;
		end else if (prog_end_w) begin
			busy_q <= 1'b0;
			if (fuse_fault) begin
				status_q <= tpi_pkg::VAL_FAULT;
			end else begin
				fuse_val_q <= prog_val_q;
				blown1_q <= blown1_q | ~arr_q;
				blown2_q <= blown2_q | arr_q;
				// Second array burnt ends all programming, first or not
				status_q <= arr_q ? tpi_pkg::VAL_DONE : tpi_pkg::VAL_READY;
			end
		end else if (busy_q) begin
			prog_cnt_q <= prog_cnt_q + 32'h1;
		end
	end
endmodule : tpi_dev

// ---- src/tpi_host.sv ----
`timescale 1ns/1ps
module tpi_host (
	input wire logic ref_clk,
	input wire logic rst_b,
	tpi_if.host bus,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	typedef enum logic [1:0] {TPI_H_IDLE, TPI_H_START, TPI_H_BIT, TPI_H_STOP} tpi_hstate_e;

	tpi_hstate_e st_q;
	logic [2:0] qcnt_q;
	logic [1:0] ph_q;
	logic [3:0] bit_q;
	logic [1:0] byte_q;
	logic [1:0] strap_q;
	logic rd_q;
	logic [7:0] instr_q;
	logic [7:0] data_q;
	logic [7:0] rx_wiper_q;
	logic [7:0] rx_valid_q;
	logic nack_q;
	logic scl_oe_q;
	logic sda_oe_q;
	logic [1:0] sda_s_q;
	logic rd_done_q;
	logic [31:0] rdata_q;

	// Byte to send for each position of the transfer
	function automatic logic [7:0] tpi_tx_byte(input logic [1:0] idx, input logic [1:0] strap,
		input logic rd, input logic [7:0] instr, input logic [7:0] data);
		tpi_tx_byte = idx == 2'h0 ? {tpi_pkg::ADDR_PREFIX, strap, rd} :
			(idx == 2'h1 ? instr : data);
	endfunction : tpi_tx_byte

	wire tick_w = qcnt_q == 3'(tpi_pkg::QTR_CYC - 1);
	wire sda_w = sda_s_q[1];
	wire rx_byte_w = rd_q && byte_q != 2'h0;
	wire last_w = byte_q == tpi_pkg::BYTES_LAST;
	wire [7:0] txb_w = tpi_tx_byte(byte_q, strap_q, rd_q, instr_q, data_q);
	wire data_bit_w = bit_q < tpi_pkg::BITS_DATA;
	wire [2:0] idx_w = 3'(4'h7 - bit_q);
	// Low drive: data zero bit, or our ack on a non-final received byte
	wire drive_w = rx_byte_w ? (!data_bit_w && !last_w) : (data_bit_w && !txb_w[idx_w]);
	wire go_w = avs_write && avs_address == tpi_pkg::REG_CMD && st_q == TPI_H_IDLE;
	wire [31:0] rmux_w = avs_address == tpi_pkg::REG_INSTR ? {24'h0, instr_q} :
		avs_address == tpi_pkg::REG_DATA ? {24'h0, data_q} :
		avs_address == tpi_pkg::REG_STAT ? {8'h0, rx_valid_q, rx_wiper_q, 6'h0, nack_q,
		st_q != TPI_H_IDLE} :
		avs_address == tpi_pkg::REG_CMD ? {29'h0, rd_q, strap_q} : 32'h0;

	assign bus.host_scl_o = 1'b0;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_scl_oe = scl_oe_q;
	assign bus.host_sda_oe = sda_oe_q;
	assign avs_waitrequest = avs_read & ~rd_done_q;
	assign avs_readdata = rdata_q;

	// Avalon register file; reads answer one cycle late from a flop
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rd_done_q <= 1'b0;
			rdata_q <= 32'h0;
			instr_q <= tpi_pkg::INSTR_RST;
			data_q <= tpi_pkg::DATA_RST;
		end else begin
			rd_done_q <= avs_read & ~rd_done_q;
			if (avs_read && !rd_done_q) begin
				rdata_q <= rmux_w;
			end
			if (avs_write && avs_address == tpi_pkg::REG_INSTR) begin
				instr_q <= avs_writedata[7:0] & 8'hef;
			end
			if (avs_write && avs_address == tpi_pkg::REG_DATA) begin
				data_q <= avs_writedata[7:0];
			end
		end
	end

	// Data line synchroniser
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			sda_s_q <= 2'h3;
		end else begin
			sda_s_q <= {sda_s_q[0], bus.sda};
		end
	end

	// Quarter-period divider; link clock period is four quarters
	always_ff @(posedge ref_clk) begin
		if (!rst_b || st_q == TPI_H_IDLE || tick_w) begin
			qcnt_q <= 3'h0;
		end else begin
			qcnt_q <= qcnt_q + 3'h1;
		end
	end

	// Transfer engine: start, up to three nine-bit bytes (a NACK stops it early), stop
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			st_q <= TPI_H_IDLE;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			byte_q <= 2'h0;
			strap_q <= 2'h0;
			rd_q <= 1'b0;
			nack_q <= 1'b0;
			rx_wiper_q <= 8'h00;
			rx_valid_q <= 8'h00;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (go_w) begin
			st_q <= TPI_H_START;
			strap_q <= avs_writedata[1:0];
			rd_q <= avs_writedata[tpi_pkg::CMD_READ];
			nack_q <= 1'b0;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			byte_q <= 2'h0;
		end else if (tick_w) begin
			ph_q <= ph_q + 2'h1;
			case (st_q)
				TPI_H_START: begin
					if (ph_q == 2'h0) begin
						sda_oe_q <= 1'b1;
					end else begin
						scl_oe_q <= 1'b1;
						ph_q <= 2'h0;
						st_q <= TPI_H_BIT;
					end
				end
				TPI_H_BIT: begin
					case (ph_q)
						2'h0: sda_oe_q <= drive_w;
						2'h1: scl_oe_q <= 1'b0;
						2'h3: begin
							scl_oe_q <= 1'b1;
							bit_q <= bit_q + 4'h1;
							if (rx_byte_w && data_bit_w && byte_q == 2'h1) begin
								rx_wiper_q <= {rx_wiper_q[6:0], sda_w};
							end
							if (rx_byte_w && data_bit_w && last_w) begin
								rx_valid_q <= {rx_valid_q[6:0], sda_w};
							end
							if (!data_bit_w) begin
								bit_q <= 4'h0;
								byte_q <= byte_q + 2'h1;
								if (!rx_byte_w && sda_w) begin
									nack_q <= 1'b1;
									st_q <= TPI_H_STOP;
								end
								if (last_w) begin
									st_q <= TPI_H_STOP;
								end
							end
						end
						default: sda_oe_q <= sda_oe_q;
					endcase
				end
				TPI_H_STOP: begin
					case (ph_q)
						2'h0: sda_oe_q <= 1'b1;
						2'h1: scl_oe_q <= 1'b0;
						2'h2: sda_oe_q <= 1'b0;
						default: st_q <= TPI_H_IDLE;
					endcase
				end
				default: st_q <= TPI_H_IDLE;
			endcase
		end
	end
endmodule : tpi_host

// ---- verif/tpi_asserts.sv ----
`timescale 1ns/1ps
module tpi_asserts #(
	parameter logic [1:0] STRAP = 2'h0
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_oe
);
	logic scl_q, sda_q, hit_q, rd_q;
	logic [3:0] bit_q;
	logic [1:0] byte_q;
	logic [7:0] sh_q;
	// Bus events seen on the resolved wires
	wire start_w = scl & scl_q & sda_q & ~sda;
	wire stop_w = scl & scl_q & ~sda_q & sda;
	wire rise_w = scl & ~scl_q;
	wire ninth_w = rise_w & (bit_q == 4'h8);
	wire match_w = (sh_q[7:1] == {tpi_pkg::ADDR_PREFIX, STRAP});
	// Wire history
	always_ff @(posedge ref_clk) begin
		scl_q <= scl;
		sda_q <= sda;
	end
	// Bit and byte position within a frame
	always_ff @(posedge ref_clk) begin
		if (!rst_b || start_w) begin
			bit_q <= 4'h0;
			byte_q <= 2'h0;
		end else if (rise_w) begin
			bit_q <= ninth_w ? 4'h0 : bit_q + 4'h1;
			byte_q <= (ninth_w && byte_q != 2'h3) ? byte_q + 2'h1 : byte_q;
			sh_q <= {sh_q[6:0], sda};
		end
	end
	// Address outcome of the current transfer
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			hit_q <= 1'b0;
			rd_q <= 1'b0;
		end else if (ninth_w && byte_q == 2'h0) begin
			hit_q <= match_w;
			rd_q <= sh_q[0];
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	sequence s_stop_soon;
		##[1:60] stop_w;
	endsequence
	property p_addr_ack;
		ninth_w && byte_q == 2'h0 |-> sda == !match_w;
	endproperty
	property p_write_ack;
		ninth_w && byte_q != 2'h0 && hit_q && !rd_q |-> !sda;
	endproperty
	property p_idle;
		byte_q != 2'h0 && !hit_q |-> !dev_sda_oe;
	endproperty
	property p_read_slot;
		ninth_w && byte_q != 2'h0 && rd_q |-> !dev_sda_oe;
	endproperty
	property p_last_nack;
		ninth_w && byte_q == 2'h2 && rd_q && hit_q |-> sda;
	endproperty
	property p_stop;
		ninth_w && byte_q == 2'h2 |-> s_stop_soon;
	endproperty
	property p_dev_edge;
		$changed(dev_sda_oe) |-> !scl;
	endproperty
	property p_start_host;
		start_w |-> !dev_sda_oe;
	endproperty
	property p_scl_high;
		$rose(scl) |=> scl [*8];
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
	a_write_ack: assert property (p_write_ack) else $error("byte not acked");
	a_idle: assert property (p_idle) else $error("unaddressed device drives");
	a_read_slot: assert property (p_read_slot) else $error("device in ack slot");
	a_last_nack: assert property (p_last_nack) else $error("last byte acked");
	a_stop: assert property (p_stop) else $error("no stop");
	a_dev_edge: assert property (p_dev_edge) else $error("data moved, clock high");
	a_start_host: assert property (p_start_host) else $error("device in start");
	a_scl_high: assert property (p_scl_high) else $error("clock high too short");
endmodule : tpi_asserts

// ---- verif/ttp_pot_i2c_slave_tb.sv ----
`timescale 1ns/1ps
module ttp_pot_i2c_slave_tb;
	localparam logic [1:0] STRAP = 2'h2;
	logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest;
	logic power_cycle, fuse_fault, wiper_shutdown, prog_busy;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd_v;
	logic [7:0] wiper_code;
	logic [1:0] fuse_status;
	int bad_count, tests_run;
	tpi_if tpi_if_i ();
	tpi_dev #(.FUSE_PROG_CYC(20)) tpi_dev_i (.ref_clk(ref_clk), .rst_b(rst_b),
		.bus(tpi_if_i.dev), .addr_strap(STRAP), .power_cycle(power_cycle),
		.fuse_fault(fuse_fault), .wiper_code(wiper_code), .wiper_shutdown(wiper_shutdown),
		.fuse_status(fuse_status), .prog_busy(prog_busy));
	tpi_host tpi_host_i (.ref_clk(ref_clk), .rst_b(rst_b), .bus(tpi_if_i.host),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	tpi_asserts #(.STRAP(STRAP)) tpi_asserts_i (.ref_clk(ref_clk), .rst_b(rst_b),
		.scl(tpi_if_i.scl), .sda(tpi_if_i.sda), .dev_sda_oe(tpi_if_i.dev_sda_oe));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude
	task automatic hang;
		bad_count++;
		$display("wait limit reached");
		conclude();
	endtask : hang
	// One Avalon access, held until waitrequest is seen low
	task automatic av(input logic rd, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= rd;
		avs_write <= !rd;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) begin
			n++;
			if (n > 20) hang();
			@(posedge ref_clk);
		end
		rd_v = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask : av
	// One link transfer, then poll until the controller is idle
	task automatic xfer(input logic [1:0] st, input logic rd, input logic [7:0] ins,
		input logic [7:0] dat);
		int n;
		n = 0;
		av(1'b0, tpi_pkg::REG_INSTR, {24'h0, ins});
		av(1'b0, tpi_pkg::REG_DATA, {24'h0, dat});
		av(1'b0, tpi_pkg::REG_CMD, {29'h0, rd, st});
		do begin
			av(1'b1, tpi_pkg::REG_STAT, 32'h0);
			n++;
			if (n > 500) hang();
		end while (rd_v[0] !== 1'b0);
	endtask : xfer
	task automatic burn_wait;
		int n;
		n = 0;
		while (prog_busy !== 1'b0) begin
			n++;
			if (n > 300) hang();
			@(posedge ref_clk);
		end
	endtask : burn_wait
	task automatic do_reset;
		rst_b <= 1'b0;
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask : do_reset
	task automatic t_reset;
		chk("wiper", wiper_code, tpi_pkg::WIPER_MIDSCALE);
		chk("fuse", fuse_status, tpi_pkg::VAL_READY);
		chk("down", wiper_shutdown, 1'b0);
		av(1'b1, 5'h10, 32'h0);
		chk("unmapped", rd_v, 32'h0);
		av(1'b0, tpi_pkg::REG_INSTR, 32'hff);
		av(1'b1, tpi_pkg::REG_INSTR, 32'h0);
		chk("instr bit4", rd_v, 32'hef);
		$display("test reset done");
	endtask : t_reset
	// Every strap value; only the matching one is acknowledged
	task automatic t_addr;
		for (int s = 0; s < 4; s++) begin
			xfer(s[1:0], 1'b0, 8'h07, 8'h40 + 8'(s));
			chk("nack", rd_v[1], s[1:0] != STRAP);
		end
		chk("wiper", wiper_code, 8'h40 + 8'(STRAP));
		xfer(STRAP, 1'b1, 8'h00, 8'h00);
		chk("rd wiper", rd_v[15:8], 8'h40 + 8'(STRAP));
		chk("rd val", rd_v[23:22], tpi_pkg::VAL_READY);
		$display("test address done");
	endtask : t_addr
	task automatic t_shutdown;
		xfer(STRAP, 1'b0, 8'h40, 8'h11);
		chk("down", wiper_shutdown, 1'b1);
		chk("wiper", wiper_code, 8'h11);
		xfer(STRAP, 1'b0, 8'h00, 8'h22);
		chk("down", wiper_shutdown, 1'b0);
		chk("wiper", wiper_code, 8'h22);
		$display("test shutdown done");
	endtask : t_shutdown
	// Burn array one, overwrite, power cycle, then burn array two
	task automatic t_prog;
		xfer(STRAP, 1'b0, 8'h20, 8'h5a);
		burn_wait();
		chk("wiper", wiper_code, 8'h5a);
		chk("fuse", fuse_status, tpi_pkg::VAL_READY);
		xfer(STRAP, 1'b0, 8'h00, 8'h77);
		chk("fused", wiper_code, 8'h5a);
		xfer(STRAP, 1'b0, 8'h08, 8'h66);
		chk("ovr", wiper_code, 8'h66);
		xfer(STRAP, 1'b0, 8'h00, 8'h01);
		chk("revert", wiper_code, 8'h5a);
		xfer(STRAP, 1'b0, 8'h08, 8'h44);
		power_cycle <= 1'b1;
		@(posedge ref_clk);
		power_cycle <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk("preset", wiper_code, 8'h5a);
		xfer(STRAP, 1'b0, 8'ha0, 8'h33);
		burn_wait();
		xfer(STRAP, 1'b0, 8'h20, 8'h10);
		burn_wait();
		xfer(STRAP, 1'b1, 8'h00, 8'h00);
		chk("rd wiper", rd_v[15:8], 8'h33);
		chk("rd val", rd_v[23:22], tpi_pkg::VAL_DONE);
		$display("test program done");
	endtask : t_prog
	// Failed burn, then array two first on a fresh die
	task automatic t_fault;
		do_reset();
		fuse_fault <= 1'b1;
		xfer(STRAP, 1'b0, 8'h20, 8'h12);
		burn_wait();
		chk("fault", fuse_status, tpi_pkg::VAL_FAULT);
		fuse_fault <= 1'b0;
		do_reset();
		xfer(STRAP, 1'b0, 8'ha0, 8'h12);
		burn_wait();
		xfer(STRAP, 1'b0, 8'h20, 8'h55);
		burn_wait();
		chk("fuse", fuse_status, tpi_pkg::VAL_DONE);
		chk("wiper", wiper_code, 8'h12);
		$display("test fault done");
	endtask : t_fault
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	initial begin
		rst_b = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		power_cycle = 1'b0;
		fuse_fault = 1'b0;
		bad_count = 0;
		tests_run = 0;
		do_reset();
		t_reset();
		t_addr();
		t_shutdown();
		t_prog();
		t_fault();
		conclude();
	end
endmodule : ttp_pot_i2c_slave_tb
